// ### hw/timer_mode_pkg.sv
// Constants for the dual timer mode-control block: register indices,
// field positions, mode encodings, reset values and bus responses.
// Assumes a 32-bit AXI4-Lite register bus, one register per aligned word.
package timer_mode_pkg;

   // ==========================================================
   // Register indices (byte address is four times the index)
   localparam logic [9:0] RUN_CTRL_IDX  = 10'h088;
   localparam logic [9:0] MODE_CFG_IDX  = 10'h089;
   localparam logic [9:0] COUNT0_IDX    = 10'h08a;
   localparam logic [9:0] COUNT1_IDX    = 10'h08b;

   // ==========================================================
   // Field positions
   localparam int RUN0_BIT     = 0;
   localparam int RUN1_BIT     = 1;
   localparam int MODE0_LSB    = 0;
   localparam int SRC0_BIT     = 2;
   localparam int FIRST_TIMER_GATE_BIT_BIT    = 3;
   localparam int MODE1_LSB    = 4;
   localparam int PRESCALE_MSB = 4;

   // ==========================================================
   // Mode field encodings
   localparam logic [1:0] MODE_PRESCALED = 2'h0;
   localparam logic [1:0] MODE_WIDE16    = 2'h1;
   localparam logic [1:0] MODE_RELOAD8   = 2'h2;
   localparam logic [1:0] MODE_STOPPED   = 2'h3;

   // ==========================================================
   // Reset values
   localparam logic [7:0]  MODE_CFG_RST = 8'h00;
   localparam logic [1:0]  RUN_CTRL_RST = 2'h0;
   localparam logic [15:0] COUNT_RST    = 16'h0000;

   // ==========================================================
   // Bus
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_RUN,
      SEL_MODE,
      SEL_CNT0,
      SEL_CNT1
   } reg_sel_t;

endpackage

// ### hw/dual_timer_mode_control.sv
// Two 16-bit timer/counters whose structure, and the first one's source and gating, are set by
// the mode configuration register, reached over AXI4-Lite.
// Assumes pins synchronous to CLK; run bits and counts sit in own registers.
`timescale 1ns/1ps

// Functional notes
// - Second timer mode 00 counts 8 bits in the high byte behind a 5-bit prescaler in the low byte.
// - Second timer mode 01 is a 16-bit counter, mode 10 an 8-bit low byte reloaded from the high byte on overflow.
// - With the first gate bit clear the first timer runs whenever its run bit is set.
// - With the first gate bit set the first timer runs only while its interrupt pin is high and its run bit set.
// - With the first source bit clear the first timer counts once every 2 system clocks while enabled.
// - With the first source bit set the first timer counts each falling edge of its count pin while enabled.
// - First timer mode 00 is 8 bits in the high byte behind a 5-bit low-byte prescaler, 01 is 16 bits.
// - First timer mode 10 counts the low byte and reloads it from the high byte on overflow.
module dual_timer_mode_control #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input  wire logic              CLK,
   input  wire logic              RST_N,
   // AXI4-Lite write address and data
   input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic              S_AXI_AWVALID,
   output logic                   S_AXI_AWREADY,
   input  wire logic [31:0]       S_AXI_WDATA,
   input  wire logic [3:0]        S_AXI_WSTRB,
   input  wire logic              S_AXI_WVALID,
   output logic                   S_AXI_WREADY,
   // AXI4-Lite write response
   output logic [1:0]             S_AXI_BRESP,
   output logic                   S_AXI_BVALID,
   input  wire logic              S_AXI_BREADY,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic              S_AXI_ARVALID,
   output logic                   S_AXI_ARREADY,
   output logic [31:0]            S_AXI_RDATA,
   output logic [1:0]             S_AXI_RRESP,
   output logic                   S_AXI_RVALID,
   input  wire logic              S_AXI_RREADY,
   // Timer pins
   input  wire logic              FIRST_EXTERNAL_IRQ_PIN,
   input  wire logic              FIRST_TIMER_COUNT_PIN,
   // Overflow pulses
   output logic                   FIRST_TIMER_OVF,
   output logic                   SECOND_TIMER_OVF
);

   // ==========================================================
   // Helpers
   function automatic timer_mode_pkg::reg_sel_t decode(
      input logic [ADDR_W-1:0] addr);
      logic [9:0] idx;
      idx = addr[11:2];
      if (addr[1:0] != 2'h0) return timer_mode_pkg::SEL_NONE;
      case (idx)
         timer_mode_pkg::RUN_CTRL_IDX: return timer_mode_pkg::SEL_RUN;
         timer_mode_pkg::MODE_CFG_IDX: return timer_mode_pkg::SEL_MODE;
         timer_mode_pkg::COUNT0_IDX:   return timer_mode_pkg::SEL_CNT0;
         timer_mode_pkg::COUNT1_IDX:   return timer_mode_pkg::SEL_CNT1;
         default:                      return timer_mode_pkg::SEL_NONE;
      endcase
   endfunction

   // One count step: returns {overflow, new count} as {ovf, high, low}
   function automatic logic [16:0] step(input logic [1:0]  mode,
                                        input logic [15:0] cnt);
      logic [4:0] pre;
      pre = cnt[timer_mode_pkg::PRESCALE_MSB:0];
      case (mode)
         timer_mode_pkg::MODE_PRESCALED:
            if (pre == 5'h1f)
               return {cnt[15:8] == 8'hff, cnt[15:8] + 8'h01, cnt[7:5],
                       5'h00};
            else
               return {1'b0, cnt[15:5], pre + 5'h01};
         timer_mode_pkg::MODE_WIDE16:
            return {cnt == 16'hffff, cnt + 16'h0001};
         timer_mode_pkg::MODE_RELOAD8:
            if (cnt[7:0] == 8'hff)
               return {1'b1, cnt[15:8], cnt[15:8]};
            else
               return {1'b0, cnt[15:8], cnt[7:0] + 8'h01};
         default:
            return {1'b0, cnt};
      endcase
   endfunction

   // ==========================================================
   // Registers
   logic [1:0]  run_q;
   logic [7:0]  mode_cfg_q;
   logic [15:0] t0_q;
   logic [15:0] t1_q;
   logic        div0_q;
   logic        div1_q;
   logic        pin_prev_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        aw_held_q;
   logic        w_held_q;

   logic [1:0] mode0;
   logic [1:0] mode1;
   logic       first_timer_gate_bit;
   logic       src0;
   logic       en0;
   logic       tick0;
   logic       tick1;
   logic       do_wr;
   logic       wr_run;
   logic       wr_mode;
   logic       wr0;
   logic       wr1;
   logic [16:0] nxt0;
   logic [16:0] nxt1;
   timer_mode_pkg::reg_sel_t wsel;
   timer_mode_pkg::reg_sel_t rsel;

   assign mode0 = mode_cfg_q[timer_mode_pkg::MODE0_LSB +: 2];
   assign mode1 = mode_cfg_q[timer_mode_pkg::MODE1_LSB +: 2];
   assign first_timer_gate_bit = mode_cfg_q[timer_mode_pkg::FIRST_TIMER_GATE_BIT_BIT];
   assign src0  = mode_cfg_q[timer_mode_pkg::SRC0_BIT];

   // Pin is already synchronous, so one stage is enough for the edge
   assign en0 = run_q[timer_mode_pkg::RUN0_BIT] &&
                (!first_timer_gate_bit || FIRST_EXTERNAL_IRQ_PIN);
   assign tick0 = en0 && (src0 ? (pin_prev_q && !FIRST_TIMER_COUNT_PIN)
                               : div0_q);
   // Second timer's gate and source bits live elsewhere: clock/2, run only
   assign tick1 = run_q[timer_mode_pkg::RUN1_BIT] && div1_q;

   assign nxt0 = step(mode0, t0_q);
   assign nxt1 = step(mode1, t1_q);

   assign wsel    = decode(awaddr_q);
   assign rsel    = decode(S_AXI_ARADDR);
   assign do_wr   = aw_held_q && w_held_q && !S_AXI_BVALID;
   assign wr_run  = do_wr && wsel == timer_mode_pkg::SEL_RUN;
   assign wr_mode = do_wr && wsel == timer_mode_pkg::SEL_MODE;
   assign wr0     = do_wr && wsel == timer_mode_pkg::SEL_CNT0;
   assign wr1     = do_wr && wsel == timer_mode_pkg::SEL_CNT1;

   // ==========================================================
   // Divide-by-two and pin edge history
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         div0_q     <= 1'b0;
         div1_q     <= 1'b0;
         pin_prev_q <= 1'b0;
      end
      else
      begin
         div0_q     <= en0 && !src0 ? !div0_q : 1'b0;
         div1_q     <= run_q[timer_mode_pkg::RUN1_BIT] ? !div1_q : 1'b0;
         pin_prev_q <= FIRST_TIMER_COUNT_PIN;
      end
   end

   // ==========================================================
   // Counters: a software write wins over a count in the same cycle
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         t0_q            <= timer_mode_pkg::COUNT_RST;
         t1_q            <= timer_mode_pkg::COUNT_RST;
         FIRST_TIMER_OVF  <= 1'b0;
         SECOND_TIMER_OVF <= 1'b0;
      end
      else
      begin
         FIRST_TIMER_OVF  <= !wr0 && tick0 && nxt0[16];
         SECOND_TIMER_OVF <= !wr1 && tick1 && nxt1[16];
         if (wr0)
         begin
            if (wstrb_q[0]) t0_q[7:0]  <= wdata_q[7:0];
            if (wstrb_q[1]) t0_q[15:8] <= wdata_q[15:8];
         end
         else if (tick0)
            t0_q <= nxt0[15:0];
         if (wr1)
         begin
            if (wstrb_q[0]) t1_q[7:0]  <= wdata_q[7:0];
            if (wstrb_q[1]) t1_q[15:8] <= wdata_q[15:8];
         end
         else if (tick1)
            t1_q <= nxt1[15:0];
      end
   end

   // ==========================================================
   // Configuration registers
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         run_q      <= timer_mode_pkg::RUN_CTRL_RST;
         mode_cfg_q <= timer_mode_pkg::MODE_CFG_RST;
      end
      else
      begin
         if (wr_run && wstrb_q[0]) run_q <= wdata_q[1:0];
         if (wr_mode && wstrb_q[0]) mode_cfg_q <= wdata_q[7:0];
      end
   end

   // ==========================================================
   // AXI4-Lite write channels: address and data taken in either order
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         aw_held_q     <= 1'b0;
         w_held_q      <= 1'b0;
         awaddr_q      <= '0;
         wdata_q       <= 32'h0000_0000;
         wstrb_q       <= 4'h0;
         S_AXI_AWREADY <= 1'b1;
         S_AXI_WREADY  <= 1'b1;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= timer_mode_pkg::RESP_OKAY;
      end
      else
      begin
         if (S_AXI_AWVALID && S_AXI_AWREADY)
         begin
            aw_held_q     <= 1'b1;
            awaddr_q      <= S_AXI_AWADDR;
            S_AXI_AWREADY <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY)
         begin
            w_held_q     <= 1'b1;
            wdata_q      <= S_AXI_WDATA;
            wstrb_q      <= S_AXI_WSTRB;
            S_AXI_WREADY <= 1'b0;
         end
         if (do_wr)
         begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wsel == timer_mode_pkg::SEL_NONE ?
                            timer_mode_pkg::RESP_SLVERR :
                            timer_mode_pkg::RESP_OKAY;
         end
         if (S_AXI_BVALID && S_AXI_BREADY)
         begin
            S_AXI_BVALID  <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY  <= 1'b1;
         end
      end
   end

   // ==========================================================
   // AXI4-Lite read channel
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         S_AXI_ARREADY <= 1'b1;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h0000_0000;
         S_AXI_RRESP   <= timer_mode_pkg::RESP_OKAY;
      end
      else if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b1;
         S_AXI_RRESP   <= timer_mode_pkg::RESP_OKAY;
         case (rsel)
            timer_mode_pkg::SEL_RUN:  S_AXI_RDATA <= {30'h0, run_q};
            timer_mode_pkg::SEL_MODE: S_AXI_RDATA <= {24'h0, mode_cfg_q};
            timer_mode_pkg::SEL_CNT0: S_AXI_RDATA <= {16'h0, t0_q};
            timer_mode_pkg::SEL_CNT1: S_AXI_RDATA <= {16'h0, t1_q};
            default:
            begin
               S_AXI_RDATA <= 32'h0000_0000;
               S_AXI_RRESP <= timer_mode_pkg::RESP_SLVERR;
            end
         endcase
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
      begin
         S_AXI_RVALID  <= 1'b0;
         S_AXI_ARREADY <= 1'b1;
      end
   end

   // ==========================================================
   // Checks
   prescale_second_a: assert property (@(posedge CLK) disable iff (!RST_N)
      (mode1 == 2'h0 && tick1 && !wr1 && t1_q[4:0] != 5'h1f)
      |=> t1_q[4:0] == 5'($past(t1_q)) + 5'h01 &&
          t1_q[15:8] == $past(t1_q[15:8]))
      else $error("second timer prescaler step wrong");

   reload_second_a: assert property (@(posedge CLK) disable iff (!RST_N)
      (mode1 == 2'h2 && tick1 && !wr1 && t1_q[7:0] == 8'hff)
      |=> t1_q[7:0] == $past(t1_q[15:8]) &&
          SECOND_TIMER_OVF)
      else $error("second timer reload wrong");

   stop_second_a: assert property (@(posedge CLK) disable iff (!RST_N)
      (mode1 == 2'h3 && !wr1)
      |=> $stable(t1_q) && !SECOND_TIMER_OVF)
      else $error("stopped second timer moved");

   ungated_rate_a: assert property (@(posedge CLK) disable iff (!RST_N)
      (!first_timer_gate_bit && run_q[0] && !src0 && mode0 == 2'h1 && !wr0)[*3]
      |-> t0_q == $past(t0_q, 2) + 16'h0001)
      else $error("ungated first timer rate wrong");

   gate_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
      (first_timer_gate_bit && !FIRST_EXTERNAL_IRQ_PIN && !wr0) |=> $stable(t0_q))
      else $error("gated first timer counted");

   half_rate_a: assert property (@(posedge CLK) disable iff (!RST_N)
      (en0 && !src0 && mode0 == 2'h1 && !wr0)[*2]
      |-> tick0 != $past(tick0) &&
          (t0_q != $past(t0_q)) == $past(tick0))
      else $error("first timer missed half-rate step");

   pin_edge_a: assert property (@(posedge CLK) disable iff (!RST_N)
      (src0 && en0 && pin_prev_q && !FIRST_TIMER_COUNT_PIN &&
       mode0 == 2'h1 && !wr0) |=> t0_q == $past(t0_q) + 16'h0001)
      else $error("first timer missed pin edge");

   prescale_first_a: assert property (@(posedge CLK) disable iff (!RST_N)
      (mode0 == 2'h0 && tick0 && !wr0 && t0_q[4:0] == 5'h1f)
      |=> t0_q[4:0] == 5'h00 &&
          t0_q[15:8] == $past(t0_q[15:8]) + 8'h01)
      else $error("first timer prescaler carry wrong");

   reload_first_a: assert property (@(posedge CLK) disable iff (!RST_N)
      (mode0 == 2'h2 && tick0 && !wr0 && t0_q[7:0] == 8'hff)
      |=> t0_q[7:0] == t0_q[15:8] && FIRST_TIMER_OVF)
      else $error("first timer reload wrong");

endmodule

// ### bench/tb_top.sv
// Self-checking bench for the dual timer mode-control block.
// Assumes the design package is compiled first; the bench is the bus master.
`timescale 1ns/1ps
module tb_top;
   // ==========================================================
   // Signals
   logic        clk     = 1'b0;
   logic        rst_n   = 1'b0;
   logic [11:0] awaddr  = 12'h000;
   logic        awvalid = 1'b0;
   logic [31:0] wdata   = 32'h0;
   logic        wvalid  = 1'b0;
   logic        bready  = 1'b0;
   logic [11:0] araddr  = 12'h000;
   logic        arvalid = 1'b0;
   logic        rready  = 1'b0;
   logic        irq     = 1'b0;
   logic        pin     = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, ovf0, ovf1;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   int          fail_count = 0;
   int          tests_run  = 0;
   int          ovf0_n     = 0;
   int          ovf1_n     = 0;
   localparam logic [11:0] run_a  = {timer_mode_pkg::RUN_CTRL_IDX, 2'b00};
   localparam logic [11:0] mode_a = {timer_mode_pkg::MODE_CFG_IDX, 2'b00};
   localparam logic [11:0] cnt0_a = {timer_mode_pkg::COUNT0_IDX, 2'b00};
   localparam logic [11:0] cnt1_a = {timer_mode_pkg::COUNT1_IDX, 2'b00};

   always #50 clk = ~clk;

   // Pulses are one cycle wide, so they are tallied here and never missed
   // while a bus task is busy
   always @(posedge clk)
   begin
      if (ovf0 === 1'b1) ovf0_n++;
      if (ovf1 === 1'b1) ovf1_n++;
   end

   dual_timer_mode_control #(.ADDR_W(12)) u_dual_timer_mode_control (
      .CLK(clk), .RST_N(rst_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .FIRST_EXTERNAL_IRQ_PIN(irq), .FIRST_TIMER_COUNT_PIN(pin),
      .FIRST_TIMER_OVF(ovf0), .SECOND_TIMER_OVF(ovf1));

   // ==========================================================
   // Reporting
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic hang(input string what);
      fail_count++;
      $display("[ERR] %0t no answer to %s", $time, what);
      stop_test();
   endtask

   task automatic chk_eq(input logic [31:0] got, exp, input string what);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_rng(input logic [31:0] got, lo, hi, input string what);
      tests_run++;
      if (!(got >= lo && got <= hi) || $isunknown(got))
      begin
         fail_count++;
         $display("[ERR] %0t %s got %h not in %h..%h", $time, what, got, lo,
                  hi);
      end
   endtask

   // ==========================================================
   // Bus master
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      int i;
      @(posedge clk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge clk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1)
         begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
      if (i == 50) hang("write");
   endtask

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      int i;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge clk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1)
         begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
      if (i == 50) hang("read");
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      chk_eq(32'(r), 32'(timer_mode_pkg::RESP_OKAY), "write response");
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      logic [1:0] r;
      axi_rd(a, d, r);
      chk_eq(32'(r), 32'(timer_mode_pkg::RESP_OKAY), "read response");
   endtask

   // Runs one timer for a fixed window of 20 cycles; the start and stop
   // writes blur the window by a step, hence the range on the count
   task automatic run_case(input bit t1, input logic [7:0] mode,
                           input logic [15:0] pre, input bit tog,
                           input int n_ovf, input logic [15:0] lo, hi);
      logic [31:0] d;
      logic [11:0] ca;
      int          n;
      ca = t1 ? cnt1_a : cnt0_a;
      wr(run_a, 32'h0);
      wr(ca, {16'h0, pre});
      wr(mode_a, {24'h0, mode});
      n = t1 ? ovf1_n : ovf0_n;
      wr(run_a, t1 ? 32'h2 : 32'h1);
      for (int i = 0; i < 20; i++)
      begin
         @(posedge clk);
         if (tog) pin <= i[1] && i < 16;
      end
      wr(run_a, 32'h0);
      rd(ca, d);
      n = (t1 ? ovf1_n : ovf0_n) - n;
      chk_eq(32'(n), 32'(n_ovf), "overflow pulses");
      chk_rng(d, {16'h0, lo}, {16'h0, hi}, "count");
   endtask

   // ==========================================================
   // Scenarios
   task automatic sc_regs();
      logic [31:0] d;
      logic [1:0]  r;
      rd(mode_a, d);
      chk_eq(d, 32'h0, "mode reset value");
      rd(cnt0_a, d);
      chk_eq(d, 32'h0, "count reset value");
      axi_rd(12'h000, d, r);
      chk_eq({d[29:0], r}, 32'(timer_mode_pkg::RESP_SLVERR), "unmapped read");
      axi_wr(12'h3fc, 32'hff, r);
      chk_eq(32'(r), 32'(timer_mode_pkg::RESP_SLVERR), "unmapped write");
      wr(mode_a, 32'hc5);
      rd(mode_a, d);
      chk_eq(d, 32'hc5, "mode readback");
   endtask

   task automatic sc_first_modes();
      run_case(0, 8'h01, 16'hfff8, 0, 1, 16'h0003, 16'h0005);
      run_case(0, 8'h00, 16'hfffc, 0, 1, 16'h00e7, 16'h00e9);
      run_case(0, 8'h02, 16'h80fc, 0, 1, 16'h8087, 16'h8089);
   endtask

   task automatic sc_gate();
      run_case(0, 8'h01, 16'h0100, 0, 0, 16'h010b, 16'h010d);
      run_case(0, 8'h09, 16'h0100, 0, 0, 16'h0100, 16'h0100);
      irq <= 1'b1;
      run_case(0, 8'h09, 16'h0100, 0, 0, 16'h010b, 16'h010d);
      irq <= 1'b0;
   endtask

   task automatic sc_count_pin();
      run_case(0, 8'h05, 16'h0000, 1, 0, 16'h0004, 16'h0004);
      pin <= 1'b0;
   endtask

   task automatic sc_second_modes();
      run_case(1, 8'h00, 16'hfffc, 0, 1, 16'h00e7, 16'h00e9);
      run_case(1, 8'h10, 16'hfff8, 0, 1, 16'h0003, 16'h0005);
      run_case(1, 8'h20, 16'h80fc, 0, 1, 16'h8087, 16'h8089);
      run_case(1, 8'h30, 16'hffff, 0, 0, 16'hffff, 16'hffff);
   endtask

   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      sc_regs();
      sc_first_modes();
      sc_gate();
      sc_count_pin();
      sc_second_modes();
      stop_test();
   end
endmodule
